// ---- shared/cfo_consts.svh ----
// Constants for the FIFO write-side control.
// Included by bare name; definitions only.
`ifndef CFO_CONSTS_SVH
`define CFO_CONSTS_SVH

`define CFO_DATA_W 36
`define CFO_MEM_DEPTH 1024
`define CFO_STAGE_DEPTH 8
`define CFO_OFF_W 10
`define CFO_OFF_MSB 9
`define CFO_SERIAL_BITS 20
`define CFO_SERIAL_LAST 5'h13
`define CFO_PRESET_SMALL 10'h008
`define CFO_PRESET_LARGE 10'h040
`define CFO_OFF_RESET 10'h000
`define CFO_MAIL_RESET 36'h0

`endif

// ---- shared/cfo_pkg.sv ----
// Types of the FIFO control block.
// Assumes nothing of its surroundings.
package cfo_pkg;

    // Gray steps along the parallel programming path
    typedef enum logic [2:0] {
        CFO_ST_RESET     = 3'h0,
        CFO_ST_WAIT      = 3'h1,
        CFO_ST_PAR_FULL  = 3'h3,
        CFO_ST_PAR_EMPTY = 3'h2,
        CFO_ST_RUN       = 3'h6,
        CFO_ST_SERIAL    = 3'h7
    } cfo_state_t;

    typedef enum logic [1:0] {
        CFO_MODE_PRESET_SMALL = 2'h0,
        CFO_MODE_PRESET_LARGE = 2'h1,
        CFO_MODE_PARALLEL     = 2'h2,
        CFO_MODE_SERIAL       = 2'h3
    } cfo_mode_t;

endpackage

// ---- shared/cfo_stream_if.sv ----
// Valid/ready stream with fill count to the staging buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cfo_stream_if #(
    parameter int WIDTH = 36,
    parameter int CW = 4
);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [CW-1:0] count;

    modport buffer (input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, count);
    modport user (output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, count);
endinterface // cfo_stream_if

// ---- core/cfo_fifo.sv ----
// Small staging FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; synchronous active-low reset.
`timescale 1ns/1ps
module cfo_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    cfo_stream_if.buffer port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] fill;
    logic push;
    logic pop;

    assign port.in_ready = (fill != CW'(DEPTH));
    assign port.out_valid = (fill != '0);
    assign port.out_data = store[rptr];
    assign port.count = fill;
    assign push = port.in_valid && port.in_ready;
    assign pop = port.out_valid && port.out_ready;

    always_ff @(posedge clk_in) begin
        if (push) begin
            store[wptr] <= port.in_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            wptr <= '0;
            rptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + AW'(1);
            end
            if (pop) begin
                rptr <= rptr + AW'(1);
            end
            if (push && !pop) begin
                fill <= fill + CW'(1);
            end else if (pop && !push) begin
                fill <= fill - CW'(1);
            end
        end
    end
endmodule // cfo_fifo

// ---- core/cfo_top.sv ----
// Write-side control of a clocked FIFO: reset, offset programming,
// port-A write qualification, mailboxes and fill flags.
// Assumes one clock for both ports; inputs synchronous.
//
// Behaviour
// - Reset accepted at any time
// - Reset clears pointers and sets flag levels
// - Reset sets both mailbox flags high
// - Release samples select pins for offset mode
// - Preset loads offsets; ready after two edges
// - Parallel mode: first two writes load offsets
// - Offsets from bus bits nine down to zero
// - After offsets loaded, writes store data
// - Serial bit shifted when strobe low
// - Twenty bits, full offset MSB first
// - Serial: ready rises edge after last bit
// - Bus driven only when select, direction low
// - Write needs select, mail low; dir, go, ready
// - Writes independent of concurrent reads
// - Near-empty, near-full and output-ready flags pass two register stages
// - Writes ignored while ready is low
// - Near-empty low at empty offset or fewer
// - Near-full low at depth minus full offset
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_top #(
    parameter int DATA_W = `CFO_DATA_W,
    parameter int MEM_DEPTH = `CFO_MEM_DEPTH,
    parameter int STAGE_DEPTH = `CFO_STAGE_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sel0_serial_bit_in,
    input wire logic sel1_serial_strobe_n_in,
    input wire logic port_a_select_n_in,
    input wire logic port_a_dir_in,
    input wire logic port_a_go_in,
    input wire logic port_a_mail_sel_in,
    input wire logic [DATA_W-1:0] port_a_bus_in,
    output logic [DATA_W-1:0] port_a_bus_out,
    output logic port_a_bus_oe_out,
    input wire logic port_b_read_in,
    input wire logic port_b_mail_write_in,
    input wire logic [DATA_W-1:0] port_b_mail_data_in,
    input wire logic port_b_mail_read_in,
    output logic [DATA_W-1:0] port_b_data_out,
    output logic [DATA_W-1:0] port_b_mail_out,
    output logic input_ready_out,
    output logic output_ready_out,
    output logic near_empty_n_out,
    output logic near_full_n_out,
    output logic mail_one_flag_n_out,
    output logic mail_two_flag_n_out,
    output logic [`CFO_OFF_W-1:0] empty_offset_out,
    output logic [`CFO_OFF_W-1:0] full_offset_out
);
    localparam int AW = $clog2(MEM_DEPTH);
    localparam int NW = $clog2(MEM_DEPTH + 1);
    localparam int SW = $clog2(STAGE_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    cfo_pkg::cfo_state_t state;
    cfo_pkg::cfo_state_t next_state;
    cfo_pkg::cfo_mode_t mode;
    logic rst_seen;
    logic [`CFO_SERIAL_BITS-1:0] ser_shift;
    logic [`CFO_SERIAL_BITS-1:0] next_ser_shift;
    logic [4:0] ser_count;
    logic [`CFO_OFF_W-1:0] empty_offset;
    logic [`CFO_OFF_W-1:0] full_offset;
    logic [DATA_W-1:0] mailbox_one;
    logic [DATA_W-1:0] mailbox_two;
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [AW-1:0] mem_wptr;
    logic [AW-1:0] mem_rptr;
    logic [NW-1:0] mem_count;
    logic [NW-1:0] full_level;
    logic [SW-1:0] next_stage_count;
    logic a_access;
    logic fifo_write;
    logic mail_one_write;
    logic mail_two_read;
    logic serial_shift;
    logic init_done;
    logic stage_push;
    logic stage_pop;
    logic mem_read;
    logic empty_s1;
    logic full_s1;
    logic ready_s1;

    cfo_stream_if #(.WIDTH(DATA_W), .CW(SW)) stage ();

    cfo_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_DEPTH),
        .CW(SW)
    ) i_cfo_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .port(stage.buffer)
    );

    ////////////////////////////////////////////////////////////////////////
    // Port-A decode

    assign a_access = !port_a_select_n_in && port_a_dir_in && port_a_go_in;
    // Ready flag gates every FIFO write
    assign fifo_write = a_access && !port_a_mail_sel_in && input_ready_out;
    assign mail_one_write = a_access && port_a_mail_sel_in;
    assign mail_two_read = !port_a_select_n_in && !port_a_dir_in
        && port_a_go_in && port_a_mail_sel_in;
    assign serial_shift = (state == cfo_pkg::CFO_ST_SERIAL)
        && !sel1_serial_strobe_n_in;
    assign next_ser_shift = {ser_shift[`CFO_SERIAL_BITS-2:0],
        sel0_serial_bit_in};
    assign init_done = (state == cfo_pkg::CFO_ST_PAR_FULL)
        || (state == cfo_pkg::CFO_ST_PAR_EMPTY)
        || (state == cfo_pkg::CFO_ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Mode capture on reset release

    // Release edge seen as first clock with reset high
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rst_seen <= 1'b0;
            mode <= cfo_pkg::CFO_MODE_PRESET_SMALL;
        end else begin
            rst_seen <= 1'b1;
            if (!rst_seen) begin
                case ({sel1_serial_strobe_n_in, sel0_serial_bit_in})
                    2'b11: begin
                        mode <= cfo_pkg::CFO_MODE_SERIAL;
                    end
                    2'b00: begin
                        mode <= cfo_pkg::CFO_MODE_PARALLEL;
                    end
                    2'b10: begin
                        mode <= cfo_pkg::CFO_MODE_PRESET_LARGE;
                    end
                    default: begin
                        mode <= cfo_pkg::CFO_MODE_PRESET_SMALL;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming sequence

    always_comb begin
        next_state = state;
        case (state)
            cfo_pkg::CFO_ST_RESET: begin
                if (!rst_seen) begin
                    if (sel1_serial_strobe_n_in && sel0_serial_bit_in) begin
                        next_state = cfo_pkg::CFO_ST_SERIAL;
                    end else begin
                        next_state = cfo_pkg::CFO_ST_WAIT;
                    end
                end
            end
            cfo_pkg::CFO_ST_WAIT: begin
                if (mode == cfo_pkg::CFO_MODE_PARALLEL) begin
                    next_state = cfo_pkg::CFO_ST_PAR_FULL;
                end else begin
                    next_state = cfo_pkg::CFO_ST_RUN;
                end
            end
            cfo_pkg::CFO_ST_PAR_FULL: begin
                if (fifo_write) begin
                    next_state = cfo_pkg::CFO_ST_PAR_EMPTY;
                end
            end
            cfo_pkg::CFO_ST_PAR_EMPTY: begin
                if (fifo_write) begin
                    next_state = cfo_pkg::CFO_ST_RUN;
                end
            end
            cfo_pkg::CFO_ST_SERIAL: begin
                if (serial_shift && ser_count == `CFO_SERIAL_LAST) begin
                    next_state = cfo_pkg::CFO_ST_RUN;
                end
            end
            cfo_pkg::CFO_ST_RUN: begin
                next_state = cfo_pkg::CFO_ST_RUN;
            end
            default: begin
                next_state = cfo_pkg::CFO_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state <= cfo_pkg::CFO_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ser_shift <= '0;
            ser_count <= 5'h00;
        end else if (serial_shift) begin
            ser_shift <= next_ser_shift;
            ser_count <= ser_count + 5'h01;
        end
    end

    // No clamping: writer keeps offsets in range
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            empty_offset <= `CFO_OFF_RESET;
            full_offset <= `CFO_OFF_RESET;
        end else if (state == cfo_pkg::CFO_ST_WAIT) begin
            if (mode == cfo_pkg::CFO_MODE_PRESET_LARGE) begin
                empty_offset <= `CFO_PRESET_LARGE;
                full_offset <= `CFO_PRESET_LARGE;
            end else if (mode == cfo_pkg::CFO_MODE_PRESET_SMALL) begin
                empty_offset <= `CFO_PRESET_SMALL;
                full_offset <= `CFO_PRESET_SMALL;
            end
        end else if (state == cfo_pkg::CFO_ST_PAR_FULL && fifo_write) begin
            full_offset <= port_a_bus_in[`CFO_OFF_MSB:0];
        end else if (state == cfo_pkg::CFO_ST_PAR_EMPTY && fifo_write) begin
            empty_offset <= port_a_bus_in[`CFO_OFF_MSB:0];
        end else if (serial_shift && ser_count == `CFO_SERIAL_LAST) begin
            full_offset <= next_ser_shift[19:10];
            empty_offset <= next_ser_shift[9:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            empty_offset_out <= `CFO_OFF_RESET;
            full_offset_out <= `CFO_OFF_RESET;
        end else begin
            empty_offset_out <= empty_offset;
            full_offset_out <= full_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data path: staging buffer drains into the main memory

    // Only writes after programming reach the data path
    assign stage_push = fifo_write && (state == cfo_pkg::CFO_ST_RUN);
    assign stage.in_valid = stage_push;
    assign stage.in_data = port_a_bus_in;
    assign stage.out_ready = (mem_count != NW'(MEM_DEPTH));
    assign stage_pop = stage.out_valid && stage.out_ready;
    assign mem_read = port_b_read_in && output_ready_out
        && (mem_count != '0);
    assign next_stage_count = stage.count
        + SW'(stage_push && stage.in_ready) - SW'(stage_pop);

    always_ff @(posedge clk_in) begin
        if (stage_pop) begin
            mem[mem_wptr] <= stage.out_data;
        end
    end

    // Write and read pointers move on their own
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mem_wptr <= '0;
            mem_rptr <= '0;
            mem_count <= '0;
        end else begin
            if (stage_pop) begin
                mem_wptr <= mem_wptr + AW'(1);
            end
            if (mem_read) begin
                mem_rptr <= mem_rptr + AW'(1);
            end
            mem_count <= mem_count + NW'(stage_pop) - NW'(mem_read);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            port_b_data_out <= '0;
        end else if (mem_read) begin
            port_b_data_out <= mem[mem_rptr];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags

    // One fill ahead: staging never overruns
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            input_ready_out <= 1'b0;
        end else begin
            input_ready_out <= init_done
                && (next_stage_count != SW'(STAGE_DEPTH));
        end
    end

    assign full_level = NW'(MEM_DEPTH) - NW'(full_offset);

    // Two stages per flag
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            empty_s1 <= 1'b0;
            near_empty_n_out <= 1'b0;
            full_s1 <= 1'b1;
            near_full_n_out <= 1'b1;
            ready_s1 <= 1'b0;
            output_ready_out <= 1'b0;
        end else begin
            empty_s1 <= (mem_count > NW'(empty_offset));
            near_empty_n_out <= empty_s1;
            full_s1 <= (mem_count < full_level);
            near_full_n_out <= full_s1;
            ready_s1 <= (mem_count != '0);
            output_ready_out <= ready_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mailboxes and port-A bus drive

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mailbox_one <= `CFO_MAIL_RESET;
            mailbox_two <= `CFO_MAIL_RESET;
        end else begin
            if (mail_one_write) begin
                mailbox_one <= port_a_bus_in;
            end
            if (port_b_mail_write_in) begin
                mailbox_two <= port_b_mail_data_in;
            end
        end
    end

    // New mail beats a same-cycle read clear
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            mail_one_flag_n_out <= 1'b1;
            mail_two_flag_n_out <= 1'b1;
        end else begin
            if (mail_one_write) begin
                mail_one_flag_n_out <= 1'b0;
            end else if (port_b_mail_read_in) begin
                mail_one_flag_n_out <= 1'b1;
            end
            if (port_b_mail_write_in) begin
                mail_two_flag_n_out <= 1'b0;
            end else if (mail_two_read) begin
                mail_two_flag_n_out <= 1'b1;
            end
        end
    end

    // Registered enable lags the pins by one clock
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            port_a_bus_oe_out <= 1'b0;
            port_a_bus_out <= '0;
            port_b_mail_out <= '0;
        end else begin
            port_a_bus_oe_out <= !port_a_select_n_in
                && !port_a_dir_in;
            port_a_bus_out <= mailbox_two;
            port_b_mail_out <= mailbox_one;
        end
    end
endmodule // cfo_top

// ---- test/cfo_top_checker.sv ----
// Concurrent checks on the FIFO write-side control's ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module cfo_top_checker #(
    parameter int DATA_W = 36
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sel0_serial_bit_in,
    input wire logic sel1_serial_strobe_n_in,
    input wire logic port_a_select_n_in,
    input wire logic port_a_dir_in,
    input wire logic port_a_go_in,
    input wire logic port_a_mail_sel_in,
    input wire logic [DATA_W-1:0] port_a_bus_in,
    input wire logic port_a_bus_oe_out,
    input wire logic [DATA_W-1:0] port_b_mail_out,
    input wire logic input_ready_out,
    input wire logic output_ready_out,
    input wire logic near_empty_n_out,
    input wire logic near_full_n_out,
    input wire logic mail_one_flag_n_out,
    input wire logic mail_two_flag_n_out,
    input wire logic [`CFO_OFF_W-1:0] empty_offset_out,
    input wire logic [`CFO_OFF_W-1:0] full_offset_out
);
    logic rst_q;
    logic serial;
    logic [4:0] bits;
    logic [19:0] shreg;
    wire logic strobe = !sel1_serial_strobe_n_in;
    wire logic mail_wr = !port_a_select_n_in && port_a_dir_in &&
        port_a_go_in && port_a_mail_sel_in;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) rst_q <= rst_b_in;
    // Mode taken at release; bits counted from the next edge
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            serial <= 1'b0;
            bits <= 5'h00;
        end else if (!rst_q) begin
            serial <= sel1_serial_strobe_n_in && sel0_serial_bit_in;
            bits <= 5'h00;
        end else if (serial && strobe && bits < 5'h14) begin
            bits <= bits + 5'h01;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_b_in && rst_q && serial && strobe && bits < 5'h14) begin
            shreg <= {shreg[18:0], sel0_serial_bit_in};
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_reset_flags: assert property (
        $rose(rst_b_in) |-> !input_ready_out && !output_ready_out &&
        !near_empty_n_out && near_full_n_out)
        else $error("Reset flag levels wrong");
    a_reset_mail: assert property (
        $rose(rst_b_in) |-> mail_one_flag_n_out && mail_two_flag_n_out)
        else $error("Reset mail flags wrong");
    a_ready_two_edges: assert property (
        $rose(rst_b_in) && !(sel1_serial_strobe_n_in && sel0_serial_bit_in)
        |-> !input_ready_out [*3] ##1 input_ready_out)
        else $error("Ready late after reset");
    a_preset_large: assert property (
        $rose(rst_b_in) && sel1_serial_strobe_n_in && !sel0_serial_bit_in
        |-> ##4 full_offset_out == `CFO_PRESET_LARGE &&
        empty_offset_out == `CFO_PRESET_LARGE)
        else $error("Large preset not loaded");
    a_serial_hold: assert property (
        serial && bits < 5'h14 |-> !input_ready_out)
        else $error("Ready before serial done");
    a_serial_rise: assert property (
        serial && bits == 5'h13 && strobe |-> ##2 input_ready_out)
        else $error("Ready late after serial");
    a_serial_value: assert property (
        serial && bits == 5'h13 && strobe
        |-> ##2 {full_offset_out, empty_offset_out} == shreg)
        else $error("Serial offsets wrong");
    a_bus_released: assert property (
        port_a_select_n_in || port_a_dir_in |=> !port_a_bus_oe_out)
        else $error("Bus driven while deselected");
    a_bus_driven: assert property (
        !port_a_select_n_in && !port_a_dir_in |=> port_a_bus_oe_out)
        else $error("Bus not driven");
    a_mail_one: assert property (
        mail_wr |=> !mail_one_flag_n_out ##1
        port_b_mail_out == $past(port_a_bus_in, 2))
        else $error("Mailbox one write lost");
endmodule // cfo_top_checker

bind cfo_top cfo_top_checker #(.DATA_W(DATA_W)) i_cfo_top_checker (
    .clk_in, .rst_b_in, .sel0_serial_bit_in, .sel1_serial_strobe_n_in,
    .port_a_select_n_in, .port_a_dir_in, .port_a_go_in, .port_a_mail_sel_in,
    .port_a_bus_in, .port_a_bus_oe_out, .port_b_mail_out, .input_ready_out,
    .output_ready_out, .near_empty_n_out, .near_full_n_out,
    .mail_one_flag_n_out, .mail_two_flag_n_out, .empty_offset_out,
    .full_offset_out);

// ---- test/cfo_host.sv ----
// Port-A host model: bus cycles, mode pins, serial offsets.
// Assumes one caller at a time; drives at falling edges.
`timescale 1ns/1ps
module cfo_host #(
    parameter int DATA_W = 36
) (
    input wire logic clk_in,
    input wire logic input_ready_in,
    output logic sel0_serial_bit_out,
    output logic sel1_serial_strobe_n_out,
    output logic port_a_select_n_out,
    output logic port_a_dir_out,
    output logic port_a_go_out,
    output logic port_a_mail_sel_out,
    output logic [DATA_W-1:0] port_a_bus_out
);
    initial begin
        {sel0_serial_bit_out, sel1_serial_strobe_n_out} = 2'h1;
        {port_a_select_n_out, port_a_dir_out} = 2'h2;
        {port_a_go_out, port_a_mail_sel_out} = 2'h0;
        port_a_bus_out = '0;
    end

    // Ready as the taking edge will see it
    task automatic drive(input logic s, d, g, m,
                         input logic [DATA_W-1:0] v, output logic acc);
        @(negedge clk_in);
        port_a_select_n_out = s;
        port_a_dir_out = d;
        port_a_go_out = g;
        port_a_mail_sel_out = m;
        port_a_bus_out = v;
        acc = input_ready_in;
    endtask

    // Released bus shows the inverse, never a stale copy
    task automatic idle();
        logic a;
        drive(1'b1, 1'b0, 1'b0, 1'b0, ~port_a_bus_out, a);
    endtask

    task automatic set_sel(input logic s1, s0);
        @(negedge clk_in);
        sel1_serial_strobe_n_out = s1;
        sel0_serial_bit_out = s0;
    endtask

    // Full offset first, MSB first; caller keeps values in 1..1020
    task automatic serial(input logic [19:0] v);
        for (int i = 19; i >= 0; i--) set_sel(1'b0, v[i]);
        set_sel(1'b1, ~v[0]);
    endtask
endmodule // cfo_host

// ---- test/tb_cfo_top.sv ----
// Self-checking bench for the FIFO write-side control.
// Host model drives port A; the bench plays port B.
`timescale 1ns/1ps
`include "cfo_consts.svh"
module tb_cfo_top;
    localparam int W = 36;
    logic clk_in, rst_b_in, s0, s1, csn, dir, go, mbx, oe, rd, mwr, mrd;
    logic ir, orr, ne, nf, mf1, mf2;
    logic [W-1:0] bus_in, bus_out, b_data, b_mail, mdata;
    logic [9:0] eoff, foff;
    logic [W-1:0] q[$];
    int miscompares = 0;
    int checks_done = 0;

    cfo_top i_cfo_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .sel0_serial_bit_in(s0), .sel1_serial_strobe_n_in(s1),
        .port_a_select_n_in(csn), .port_a_dir_in(dir), .port_a_go_in(go),
        .port_a_mail_sel_in(mbx), .port_a_bus_in(bus_in),
        .port_a_bus_out(bus_out), .port_a_bus_oe_out(oe),
        .port_b_read_in(rd), .port_b_mail_write_in(mwr),
        .port_b_mail_data_in(mdata), .port_b_mail_read_in(mrd),
        .port_b_data_out(b_data), .port_b_mail_out(b_mail),
        .input_ready_out(ir), .output_ready_out(orr),
        .near_empty_n_out(ne), .near_full_n_out(nf),
        .mail_one_flag_n_out(mf1), .mail_two_flag_n_out(mf2),
        .empty_offset_out(eoff), .full_offset_out(foff));
    cfo_host i_cfo_host (.clk_in(clk_in), .input_ready_in(ir),
        .sel0_serial_bit_out(s0), .sel1_serial_strobe_n_out(s1),
        .port_a_select_n_out(csn), .port_a_dir_out(dir),
        .port_a_go_out(go), .port_a_mail_sel_out(mbx),
        .port_a_bus_out(bus_in));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [W+1:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset(input logic m1, m0);
        i_cfo_host.set_sel(m1, m0);
        rst_b_in = 1'b0;
        repeat (6) @(negedge clk_in);
        check("reset_flags", {ir, orr, ne, nf, mf1, mf2}, 6'h07);
        rst_b_in = 1'b1;
    endtask

    task automatic put(output logic a);
        logic [W-1:0] d;
        d = {4'($urandom), $urandom};
        i_cfo_host.drive(1'b0, 1'b1, 1'b1, 1'b0, d, a);
        if (a) q.push_back(d);
    endtask

    // Port B: each accepted read pops the oldest note
    always @(posedge clk_in) begin
        if (rd && orr) begin
            #1;
            check("fifo_word", b_data, q.size() ? q.pop_front() : 'x);
        end
    end

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        miscompares++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic a;
        logic [9:0] f, e;
        logic [W-1:0] d;
        {rst_b_in, rd, mwr, mrd, mdata} = '0;
        n = $urandom(11575);
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0], !m[0]);
            repeat (5) @(negedge clk_in);
            check("preset_ready", ir, 1);
            check("preset_full", foff,
                  m ? `CFO_PRESET_LARGE : `CFO_PRESET_SMALL);
            check("preset_empty", eoff,
                  m ? `CFO_PRESET_LARGE : `CFO_PRESET_SMALL);
        end
        do_reset(1'b1, 1'b1);
        f = 10'($urandom_range(1020, 1));
        e = 10'($urandom_range(1020, 1));
        i_cfo_host.drive(1'b0, 1'b1, 1'b1, 1'b0, W'($urandom), a);
        i_cfo_host.idle();
        i_cfo_host.serial({f, e});
        check("serial_wait", ir, 0);
        @(negedge clk_in);
        check("serial_ready", ir, 1);
        check("serial_offs", {foff, eoff}, {f, e});
        check("no_store_low_ready", orr, 0);
        do_reset(1'b0, 1'b0);
        n = 0;
        while (ir !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        // Random high bits: only bits 9..0 form an offset
        d = {26'($urandom), 10'h3FC};
        i_cfo_host.drive(1'b0, 1'b1, 1'b1, 1'b0, d, a);
        d = {26'($urandom), 10'h002};
        i_cfo_host.drive(1'b0, 1'b1, 1'b1, 1'b0, d, a);
        d = {4'($urandom), $urandom};
        i_cfo_host.drive(1'b0, 1'b1, 1'b0, 1'b0, ~d, a);
        i_cfo_host.drive(1'b0, 1'b1, 1'b1, 1'b1, d, a);
        i_cfo_host.idle();
        repeat (2) @(negedge clk_in);
        check("par_offs", {foff, eoff}, {10'h3FC, 10'h002});
        check("mail_one", {mf1, b_mail}, {1'b0, d});
        mrd = 1'b1;
        mwr = 1'b1;
        mdata = ~d;
        @(negedge clk_in);
        {mrd, mwr} = 2'h0;
        check("mail_flags", {mf1, mf2}, 2'h2);
        i_cfo_host.drive(1'b0, 1'b0, 1'b1, 1'b1, d, a);
        i_cfo_host.idle();
        check("mail_two", {oe, mf2, bus_out}, {2'h3, ~d});
        check("no_store_refused", orr, 0);
        for (int i = 0; i < 4; i++) begin
            put(a);
            i_cfo_host.idle();
            repeat (6) @(negedge clk_in);
            check("near_empty", ne, i >= 2);
            check("near_full", nf, i < 3);
        end
        n = 0;
        do begin
            put(a);
            n++;
        end while (a && n < 1100);
        i_cfo_host.idle();
        check("full_refused", a, 0);
        // Reads spaced: ready trails the count by two edges
        n = 0;
        while (q.size() > 0 && n < 4000) begin
            @(negedge clk_in);
            rd = 1'b1;
            if (n == 0) put(a);
            else @(negedge clk_in);
            rd = 1'b0;
            if (n == 0) i_cfo_host.idle();
            repeat (3 + $urandom % 4) @(negedge clk_in);
            n++;
        end
        repeat (6) @(negedge clk_in);
        check("drained", {orr, ne, q.size() == 0}, 3'h1);
        wrap_up();
    end
endmodule // tb_cfo_top
